// *** hdl/irqc_top.sv ***
`timescale 1ns/1ps
module irqc_top #(
  parameter bit HAS_ADC = 1'b1
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // register port
  input  wire irqc_pkg::irqc_bus_s bus,
  output logic [7:0]             rdata,
  // request sources
  input  wire logic              ext_pin,
  input  wire logic              comparator_evt,
  input  wire logic              timebase0_evt,
  input  wire logic              timebase1_evt,
  input  wire logic              converter_evt,
  input  wire logic              group0_evt,
  input  wire logic              group2_evt,
  // interrupt outputs
  output logic                   irq,
  output logic                   irq_take
);

  irqc_pkg::irqc_state_s st_ff;
  irqc_pkg::irqc_state_s nxt_st;

  // ===========================================================================
  // edge detect
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
    case (sel)
      irqc_pkg::EDGE_OFF:  edge_hit = 1'b0;
      irqc_pkg::EDGE_RISE: edge_hit = cur & ~prev;
      irqc_pkg::EDGE_FALL: edge_hit = ~cur & prev;
      irqc_pkg::EDGE_BOTH: edge_hit = cur ^ prev;
      default:             edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  logic [7:0]           c1_mask;
  logic                 pin_evt;
  logic [irqc_pkg::NSRC-1:0] evt;
  logic [irqc_pkg::NSRC-1:0] pend;

  assign c1_mask = HAS_ADC ? irqc_pkg::C1_MASK : irqc_pkg::C1_MASK_NA;
  assign pin_evt = edge_hit(st_ff.edge_sel, ext_pin, st_ff.pin_prev);
  assign evt = {group2_evt, converter_evt & HAS_ADC, timebase1_evt, timebase0_evt,
                group0_evt, comparator_evt, pin_evt};

  // source-enabled pending requests
  always_comb begin
    pend[0] = st_ff.ctrl0[irqc_pkg::C0_PINF] & st_ff.ctrl0[irqc_pkg::C0_PINE];
    pend[1] = st_ff.ctrl0[irqc_pkg::C0_CPF] & st_ff.ctrl0[irqc_pkg::C0_CPE];
    pend[2] = st_ff.ctrl0[irqc_pkg::C0_G0F] & st_ff.ctrl0[irqc_pkg::C0_G0E];
    pend[3] = st_ff.ctrl1[irqc_pkg::C1_T0F] & st_ff.ctrl1[irqc_pkg::C1_T0E];
    pend[4] = st_ff.ctrl2[irqc_pkg::C2_T1F] & st_ff.ctrl2[irqc_pkg::C2_T1E];
    pend[5] = st_ff.ctrl1[irqc_pkg::C1_ADF] & st_ff.ctrl1[irqc_pkg::C1_ADE];
    pend[6] = st_ff.ctrl1[irqc_pkg::C1_G2F] & st_ff.ctrl1[irqc_pkg::C1_G2E];
  end

  // ===========================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_prev = ext_pin;
    if (bus.wr) begin
      case (bus.addr)
        irqc_pkg::ADDR_EDGE:  nxt_st.edge_sel = bus.wdata[1:0];
        irqc_pkg::ADDR_CTRL0: nxt_st.ctrl0 = bus.wdata & irqc_pkg::C0_MASK;
        irqc_pkg::ADDR_CTRL1: nxt_st.ctrl1 = bus.wdata & c1_mask;
        irqc_pkg::ADDR_CTRL2: nxt_st.ctrl2 = bus.wdata & irqc_pkg::C2_MASK;
        irqc_pkg::ADDR_GRP0:  nxt_st.grp0 = bus.wdata;
        irqc_pkg::ADDR_GRP1:  nxt_st.grp1 = bus.wdata;
        irqc_pkg::ADDR_GRP2:  nxt_st.grp2 = bus.wdata & irqc_pkg::G2_MASK;
        irqc_pkg::ADDR_MASK:  nxt_st.mask = bus.wdata[irqc_pkg::NSRC-1:0];
        default: ;
      endcase
    end
    if (bus.rd && bus.addr == irqc_pkg::ADDR_STAT) begin
      nxt_st.stat = '0;
    end
    // hardware set wins over software write or clear
    if (evt[0]) nxt_st.ctrl0[irqc_pkg::C0_PINF] = 1'b1;
    if (evt[1]) nxt_st.ctrl0[irqc_pkg::C0_CPF] = 1'b1;
    if (evt[2]) nxt_st.ctrl0[irqc_pkg::C0_G0F] = 1'b1;
    if (evt[3]) nxt_st.ctrl1[irqc_pkg::C1_T0F] = 1'b1;
    if (evt[4]) nxt_st.ctrl2[irqc_pkg::C2_T1F] = 1'b1;
    if (evt[5]) nxt_st.ctrl1[irqc_pkg::C1_ADF] = 1'b1;
    if (evt[6]) nxt_st.ctrl1[irqc_pkg::C1_G2F] = 1'b1;
    nxt_st.stat = nxt_st.stat | evt;
    nxt_st.take = st_ff.ctrl0[irqc_pkg::C0_GIE] & (|pend);
    nxt_st.irq = |(nxt_st.stat & st_ff.mask);
    nxt_st.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        irqc_pkg::ADDR_EDGE:  nxt_st.rdata = {6'h00, st_ff.edge_sel};
        irqc_pkg::ADDR_CTRL0: nxt_st.rdata = st_ff.ctrl0;
        irqc_pkg::ADDR_CTRL1: nxt_st.rdata = st_ff.ctrl1 & c1_mask;
        irqc_pkg::ADDR_CTRL2: nxt_st.rdata = st_ff.ctrl2;
        irqc_pkg::ADDR_GRP0:  nxt_st.rdata = st_ff.grp0;
        irqc_pkg::ADDR_GRP1:  nxt_st.rdata = st_ff.grp1;
        irqc_pkg::ADDR_GRP2:  nxt_st.rdata = st_ff.grp2;
        irqc_pkg::ADDR_STAT:  nxt_st.rdata = {1'b0, st_ff.stat};
        irqc_pkg::ADDR_MASK:  nxt_st.rdata = {1'b0, st_ff.mask};
        default:              nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // ===========================================================================
  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff          <= '0;
      st_ff.edge_sel <= irqc_pkg::EDGE_RST;
      st_ff.grp1     <= irqc_pkg::GRP1_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata    = st_ff.rdata;
  assign irq      = st_ff.irq;
  assign irq_take = st_ff.take;

  // ===========================================================================
  // checks
  a_rise_only_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff.edge_sel == 2'b01 && ext_pin && !st_ff.pin_prev)
      |=> st_ff.ctrl0[irqc_pkg::C0_PINF]) else $error("rising edge missed");
  a_off_no_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff.edge_sel == 2'b00 && !(bus.wr && bus.addr == irqc_pkg::ADDR_CTRL0)
     && !st_ff.ctrl0[irqc_pkg::C0_PINF]) |=> !st_ff.ctrl0[irqc_pkg::C0_PINF])
    else $error("pin flag set while disabled");
  a_fall_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff.edge_sel[1] && !ext_pin && st_ff.pin_prev)
      |=> st_ff.ctrl0[irqc_pkg::C0_PINF]) else $error("falling edge missed");
  a_edge_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus.rd && bus.addr == irqc_pkg::ADDR_EDGE) |=> rdata[7:2] == 6'h00)
    else $error("edge register upper bits nonzero");
  a_gie_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_ff.ctrl0[irqc_pkg::C0_GIE] |=> !irq_take) else $error("take without global enable");
  a_pin_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff.ctrl0[irqc_pkg::C0_GIE] && pend[0]) |=> irq_take) else $error("pin take missed");
  a_grp0_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    group0_evt |=> st_ff.ctrl0[irqc_pkg::C0_G0F]) else $error("group0 flag missed");
  a_tb0_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timebase0_evt |=> st_ff.ctrl1[irqc_pkg::C1_T0F]) else $error("timebase0 flag missed");
  a_grp2_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    group2_evt |=> st_ff.ctrl1[irqc_pkg::C1_G2F]) else $error("group2 flag missed");
  a_c1_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus.rd && bus.addr == irqc_pkg::ADDR_CTRL1) |=> (rdata[4] == 1'b0 && rdata[0] == 1'b0))
    else $error("reserved control bits nonzero");
  a_flag_no_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (comparator_evt && !st_ff.ctrl0[irqc_pkg::C0_CPE]) |=> st_ff.ctrl0[irqc_pkg::C0_CPF])
    else $error("flag gated by enable");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|(st_ff.stat & st_ff.mask)) |-> ##[0:1] irq) else $error("interrupt output missing");

  a_conv_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (converter_evt && HAS_ADC) |=> st_ff.ctrl1[irqc_pkg::C1_ADF])
    else $error("converter flag missed");
  a_grp2_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff.ctrl0[irqc_pkg::C0_GIE] && st_ff.ctrl1[irqc_pkg::C1_G2F]
     && st_ff.ctrl1[irqc_pkg::C1_G2E]) |=> irq_take)
    else $error("group2 take missed");
  a_stat_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus.rd && bus.addr == irqc_pkg::ADDR_STAT && !(|evt)) |=> st_ff.stat == '0)
    else $error("status not cleared by read");
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !bus.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");

  c_pin_take: cover property (@(posedge ref_clk) disable iff (!rst_n) pin_evt ##[1:3] irq_take);
  c_conv_flag: cover property (@(posedge ref_clk) disable iff (!rst_n)
    converter_evt ##1 st_ff.ctrl1[irqc_pkg::C1_ADF]);
  c_stat_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
    irq ##1 (bus.rd && bus.addr == irqc_pkg::ADDR_STAT));
  c_both_edges: cover property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff.edge_sel == 2'b11 && pin_evt) ##[1:10] pin_evt);

endmodule : irqc_top

// *** hdl/irqc_pkg.sv ***
package irqc_pkg;

  // ===========================================================================
  // register map
  localparam logic [3:0] ADDR_EDGE   = 4'h0;
  localparam logic [3:0] ADDR_CTRL0  = 4'h1;
  localparam logic [3:0] ADDR_CTRL1  = 4'h2;
  localparam logic [3:0] ADDR_CTRL2  = 4'h3;
  localparam logic [3:0] ADDR_GRP0   = 4'h4;
  localparam logic [3:0] ADDR_GRP1   = 4'h5;
  localparam logic [3:0] ADDR_GRP2   = 4'h6;
  localparam logic [3:0] ADDR_STAT   = 4'h7;
  localparam logic [3:0] ADDR_MASK   = 4'h8;

  // ===========================================================================
  // bit positions
  localparam int C0_GIE  = 0;
  localparam int C0_PINE = 1;
  localparam int C0_CPE  = 2;
  localparam int C0_G0E  = 3;
  localparam int C0_PINF = 4;
  localparam int C0_CPF  = 5;
  localparam int C0_G0F  = 6;
  localparam int C1_G2E  = 1;
  localparam int C1_ADE  = 2;
  localparam int C1_T0E  = 3;
  localparam int C1_G2F  = 5;
  localparam int C1_ADF  = 6;
  localparam int C1_T0F  = 7;
  localparam int C2_T1E  = 0;
  localparam int C2_T1F  = 4;

  // ===========================================================================
  // writable masks and reset values
  localparam logic [7:0] C0_MASK    = 8'h7F;
  localparam logic [7:0] C1_MASK    = 8'hEE;
  localparam logic [7:0] C1_MASK_NA = 8'hAA;
  localparam logic [7:0] C2_MASK    = 8'h11;
  localparam logic [7:0] G2_MASK    = 8'h33;
  localparam logic [1:0] EDGE_RST   = 2'h3;
  localparam logic [7:0] GRP1_RST   = 8'h00;
  localparam int         NSRC       = 7;

  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } irqc_edge_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } irqc_bus_s;

  typedef struct packed {
    logic [1:0]      edge_sel;
    logic [7:0]      ctrl0;
    logic [7:0]      ctrl1;
    logic [7:0]      ctrl2;
    logic [7:0]      grp0;
    logic [7:0]      grp1;
    logic [7:0]      grp2;
    logic [NSRC-1:0] stat;
    logic [NSRC-1:0] mask;
    logic            pin_prev;
    logic [7:0]      rdata;
    logic            irq;
    logic            take;
  } irqc_state_s;

endpackage : irqc_pkg

// *** verification/irqc_src.sv ***
`timescale 1ns/1ps
// ============================================================================
// request sources: pin level and one-cycle event pulses
module irqc_src (
  // clock
  input  wire logic       ref_clk,
  // commands from the bench
  input  wire logic       pin_lvl,
  input  wire logic [6:0] fire,
  // request lines
  output logic            ext_pin,
  output logic [5:0]      evt
);
  always @(posedge ref_clk) begin
    ext_pin <= pin_lvl;
    evt     <= fire[6:1];
  end
endmodule : irqc_src

// *** verification/irqc_top_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module irqc_top_test;
  logic                ref_clk = 1'b0;
  logic                rst_n   = 1'b0;
  irqc_pkg::irqc_bus_s bus     = '0;
  logic [7:0]          rdata;
  logic                pin_lvl = 1'b0;
  logic [6:0]          fire    = '0;
  logic                ext_pin, irq, irq_take;
  logic [5:0]          evt;
  int                  error_cnt = 0;
  int                  n_checks  = 0;
  always #25 ref_clk = ~ref_clk;
  irqc_src src_u (.ref_clk(ref_clk), .pin_lvl(pin_lvl), .fire(fire), .ext_pin(ext_pin),
    .evt(evt));
  irqc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .ext_pin(ext_pin), .comparator_evt(evt[0]), .group0_evt(evt[1]), .timebase0_evt(evt[2]),
    .timebase1_evt(evt[3]), .converter_evt(evt[4]), .group2_evt(evt[5]), .irq(irq),
    .irq_take(irq_take));
  // ==========================================================================
  // bus and source tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) bus <= '0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] ex);
    @(posedge ref_clk) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) bus <= '0;
    @(negedge ref_clk) `CHK("rdata", ex, rdata)
  endtask : rchk
  task automatic pulse(input logic [6:0] m);
    @(posedge ref_clk) fire <= m;
    @(posedge ref_clk) fire <= '0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : pulse
  task automatic pin(input logic v);
    @(posedge ref_clk) pin_lvl <= v;
    repeat (4) @(posedge ref_clk);
  endtask : pin
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rchk(irqc_pkg::ADDR_EDGE, 8'h03);
    rchk(irqc_pkg::ADDR_CTRL0, 8'h00);
    rchk(irqc_pkg::ADDR_CTRL1, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_edges();
    for (int m = 0; m < 4; m++) begin
      wr(irqc_pkg::ADDR_EDGE, 8'(m));
      wr(irqc_pkg::ADDR_CTRL0, 8'h00);
      pin(1'b1);
      rchk(irqc_pkg::ADDR_CTRL0, m[0] ? 8'h10 : 8'h00);
      wr(irqc_pkg::ADDR_CTRL0, 8'h00);
      pin(1'b0);
      rchk(irqc_pkg::ADDR_CTRL0, m[1] ? 8'h10 : 8'h00);
    end
    wr(irqc_pkg::ADDR_EDGE, 8'hFF);
    rchk(irqc_pkg::ADDR_EDGE, 8'h03);
    wr(irqc_pkg::ADDR_CTRL1, 8'hFF);
    rchk(irqc_pkg::ADDR_CTRL1, irqc_pkg::C1_MASK);
    $display("test edges done");
  endtask : t_edges
  task automatic t_flags();
    wr(irqc_pkg::ADDR_CTRL0, 8'h00);
    wr(irqc_pkg::ADDR_CTRL1, 8'h00);
    pulse(7'h04);
    rchk(irqc_pkg::ADDR_CTRL0, 8'h40);
    pulse(7'h08);
    rchk(irqc_pkg::ADDR_CTRL1, 8'h80);
    pulse(7'h20);
    rchk(irqc_pkg::ADDR_CTRL1, 8'hC0);
    pulse(7'h40);
    rchk(irqc_pkg::ADDR_CTRL1, 8'hE0);
    pulse(7'h10);
    rchk(irqc_pkg::ADDR_CTRL2, 8'h10);
    wr(irqc_pkg::ADDR_GRP2, 8'hFF);
    rchk(irqc_pkg::ADDR_GRP2, 8'h33);
    `CHK("take", 1'b0, irq_take)
    wr(irqc_pkg::ADDR_CTRL0, 8'h48);
    `CHK("take", 1'b0, irq_take)
    wr(irqc_pkg::ADDR_CTRL0, 8'h49);
    `CHK("take", 1'b1, irq_take)
    wr(irqc_pkg::ADDR_CTRL0, 8'h01);
    wr(irqc_pkg::ADDR_CTRL1, 8'h20);
    `CHK("take", 1'b0, irq_take)
    wr(irqc_pkg::ADDR_CTRL1, 8'h22);
    `CHK("take", 1'b1, irq_take)
    wr(irqc_pkg::ADDR_CTRL1, 8'h00);
    wr(irqc_pkg::ADDR_CTRL0, 8'h13);
    `CHK("take", 1'b1, irq_take)
    wr(irqc_pkg::ADDR_CTRL0, 8'h11);
    `CHK("take", 1'b0, irq_take)
    $display("test flags done");
  endtask : t_flags
  task automatic t_status();
    rchk(irqc_pkg::ADDR_STAT, 8'h7D);
    wr(irqc_pkg::ADDR_MASK, 8'h04);
    pulse(7'h02);
    `CHK("irq", 1'b0, irq)
    pulse(7'h04);
    `CHK("irq", 1'b1, irq)
    rchk(irqc_pkg::ADDR_STAT, 8'h06);
    rchk(irqc_pkg::ADDR_STAT, 8'h00);
    `CHK("irq", 1'b0, irq)
    wr(4'hF, 8'hFF);
    rchk(4'hF, 8'h00);
    $display("test status done");
  endtask : t_status
  // ==========================================================================
  // verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // group 1 register is never accessed here
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_edges();
    t_flags();
    t_status();
    tally_and_finish();
  end
  initial begin
    #200us;
    error_cnt++;
    tally_and_finish();
  end
endmodule : irqc_top_test
